// *** src/sba_pkg.sv ***
package sba_pkg;

   // ======================================================
   // instruction encodings
   localparam logic [5:0]  SUB_REG_PREFIX = 6'h15;
   localparam logic [7:0]  SUB_LIT_PREFIX = 8'h08;
   localparam logic [7:0]  INDEX_LIMIT    = 8'h5F;
   localparam logic [5:0]  SFR_BANK       = 6'h3F;
   localparam logic [5:0]  LOW_BANK       = 6'h00;

   // ======================================================
   // register map (byte addresses, low address byte)
   localparam logic [7:0]  CTRL_OFS       = 8'h00;
   localparam logic [7:0]  INSTR_OFS      = 8'h04;
   localparam logic [7:0]  ACC_OFS        = 8'h08;
   localparam logic [7:0]  STATUS_OFS     = 8'h0C;
   localparam logic [7:0]  BANK_SEL_OFS   = 8'h10;
   localparam logic [7:0]  INDEX_BASE_OFS = 8'h14;
   localparam logic [7:0]  LAST_ADDR_OFS  = 8'h18;
   localparam logic [7:0]  RAM_BASE_OFS   = 8'h80;

   // control register bits
   localparam int          CTRL_GO_BIT      = 0;
   localparam int          CTRL_EXT_BIT     = 1;
   localparam int          CTRL_BUSY_BIT    = 2;
   localparam int          CTRL_ILLEGAL_BIT = 3;

   // status bit positions, matching sba_flags_s
   localparam int          FLAG_C_BIT  = 0;
   localparam int          FLAG_DC_BIT = 1;
   localparam int          FLAG_Z_BIT  = 2;
   localparam int          FLAG_OV_BIT = 3;
   localparam int          FLAG_N_BIT  = 4;

   // ======================================================
   // reset values
   localparam logic [7:0]  ACC_RST        = 8'h00;
   localparam logic [15:0] INSTR_RST      = 16'h0000;
   localparam logic [5:0]  BANK_SEL_RST   = 6'h00;
   localparam logic [13:0] INDEX_BASE_RST = 14'h0000;

   // ======================================================
   // bus constants
   localparam logic        HRESP_OKAY = 1'b0;

   // ======================================================
   // types
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_Q1   = 3'b001,
      ST_Q2   = 3'b010,
      ST_Q3   = 3'b011,
      ST_Q4   = 3'b100
   } sba_state_e;

   typedef enum logic [1:0] {
      OP_NONE    = 2'b00,
      OP_SUB_REG = 2'b01,
      OP_SUB_LIT = 2'b10
   } sba_op_e;

   typedef struct packed {
      logic n;
      logic ov;
      logic z;
      logic dc;
      logic c;
   } sba_flags_s;

   localparam sba_flags_s FLAGS_RST = 5'h00;

   typedef struct packed {
      sba_op_e    op;
      logic       to_reg;
      logic       bank_sel;
      logic [7:0] operand_byte;
   } sba_instr_s;

endpackage : sba_pkg

// *** src/sba_sub_alu.sv ***
module sba_sub_alu (
   // operands
   input  wire logic [7:0]         minuend_i,
   input  wire logic [7:0]         subtrahend_i,
   input  wire logic               borrow_i,
   // result
   output logic      [7:0]         result_o,
   output sba_pkg::sba_flags_s     flags_o
);

   logic [8:0] diff;
   logic [4:0] nib;

   // extra top bit catches the borrow out of each width
   assign diff = {1'b0, minuend_i} - {1'b0, subtrahend_i}
                 - {8'h00, borrow_i};
   assign nib  = {1'b0, minuend_i[3:0]} - {1'b0, subtrahend_i[3:0]}
                 - {4'h0, borrow_i};

   assign result_o   = diff[7:0];
   assign flags_o.c  = ~diff[8];
   assign flags_o.dc = ~nib[4];
   assign flags_o.z  = (diff[7:0] == 8'h00);
   assign flags_o.n  = diff[7];
   // signed wrap: operands differ in sign, result sign follows subtrahend
   assign flags_o.ov = (minuend_i[7] ^ subtrahend_i[7])
                       & (diff[7] ^ minuend_i[7]);

endmodule : sba_sub_alu

// *** src/sba_core.sv ***
// Functional notes
// - register subtract computes acc minus reg minus borrow
// - target bit clear writes result to accumulator
// - target bit set writes result to register
// - bank bit picks access bank or bank select
// - extended set indexes offsets at or below 5Fh
// - register subtract runs decode, read, process, write
// - literal subtract computes literal minus accumulator
// - literal subtract completes in four quarter phases
// - both update sign, wrap, carry, digit, zero
//
// Implementation choices: the address map and the AHB-Lite interface to the registers.
module sba_core #(
   parameter int DEPTH = 32
) (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   // ahb-lite slave
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic             hreadyout_o,
   output logic             hresp_o,
   output logic      [31:0] hrdata_o,
   // status
   output logic             busy_o
);

   localparam int IDXW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   // ======================================================
   // elaboration checks
   if (DEPTH < 2 || DEPTH > 32 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
      $error("DEPTH must be a power of two from 2 to 32");
   end

   // ======================================================
   // functions
   function automatic logic reg_hit(input logic [7:0] a,
                                    input logic [7:0] ofs);
      return a == ofs;
   endfunction : reg_hit

   function automatic sba_pkg::sba_instr_s decode(input logic [15:0] w);
      sba_pkg::sba_instr_s d;
      d.op           = sba_pkg::OP_NONE;
      d.to_reg       = w[9];
      d.bank_sel     = w[8];
      d.operand_byte = w[7:0];
      if (w[15:10] == sba_pkg::SUB_REG_PREFIX) begin
         d.op = sba_pkg::OP_SUB_REG;
      end else if (w[15:8] == sba_pkg::SUB_LIT_PREFIX) begin
         d.op = sba_pkg::OP_SUB_LIT;
      end
      return d;
   endfunction : decode

   // ======================================================
   // state
   sba_pkg::sba_state_e  state;
   sba_pkg::sba_state_e  next_state;
   sba_pkg::sba_instr_s  dec;
   sba_pkg::sba_flags_s  flags;
   sba_pkg::sba_flags_s  res_flags;
   sba_pkg::sba_flags_s  alu_flags;
   logic [15:0]          instr;
   logic [7:0]           acc;
   logic [5:0]           bank_select_register;
   logic [13:0]          index_base;
   logic [13:0]          last_addr;
   logic                 ext_en;
   logic                 illegal;
   logic [7:0]           opnd;
   logic [7:0]           res;
   logic [7:0]           alu_res;
   logic [7:0]           ram [DEPTH];

   // bus data phase
   logic                 dp_valid;
   logic                 dp_write;
   logic                 dp_hi_zero;
   logic [7:0]           dp_addr;

   // ======================================================
   // bus decode
   wire        busy      = (state != sba_pkg::ST_IDLE);
   wire        accept    = hsel_i & htrans_i[1] & hready_i;
   wire        dp_go     = dp_valid & ~busy;
   wire        bus_wr    = dp_go & dp_write;
   wire        hit_ctrl  = dp_hi_zero & reg_hit(dp_addr, sba_pkg::CTRL_OFS);
   wire        hit_instr = dp_hi_zero & reg_hit(dp_addr, sba_pkg::INSTR_OFS);
   wire        hit_acc   = dp_hi_zero & reg_hit(dp_addr, sba_pkg::ACC_OFS);
   wire        hit_stat  = dp_hi_zero
                           & reg_hit(dp_addr, sba_pkg::STATUS_OFS);
   wire        hit_bank  = dp_hi_zero
                           & reg_hit(dp_addr, sba_pkg::BANK_SEL_OFS);
   wire        hit_base  = dp_hi_zero
                           & reg_hit(dp_addr, sba_pkg::INDEX_BASE_OFS);
   wire        hit_last  = dp_hi_zero
                           & reg_hit(dp_addr, sba_pkg::LAST_ADDR_OFS);
   wire [4:0]  ram_word  = dp_addr[6:2];
   wire        hit_ram   = dp_hi_zero & dp_addr[7] & (dp_addr[1:0] == 2'b00)
                           & ({27'h0, ram_word} < DEPTH);
   wire        start     = bus_wr & hit_ctrl & hwdata_i[sba_pkg::CTRL_GO_BIT];

   wire [31:0] ctrl_rd   = {28'h0, illegal, busy, ext_en, 1'b0};
   wire [31:0] rd_data   =
      hit_ctrl  ? ctrl_rd :
      hit_instr ? {16'h0, instr} :
      hit_acc   ? {24'h0, acc} :
      hit_stat  ? {27'h0, flags} :
      hit_bank  ? {26'h0, bank_select_register} :
      hit_base  ? {18'h0, index_base} :
      hit_last  ? {18'h0, last_addr} :
      hit_ram   ? {24'h0, ram[ram_word[IDXW-1:0]]} : 32'h0;

   // reads stall while an instruction cycle runs, so no torn values
   assign hreadyout_o = ~(dp_valid & busy);
   assign hresp_o     = sba_pkg::HRESP_OKAY;
   assign hrdata_o    = (dp_go & ~dp_write) ? rd_data : 32'h0;
   assign busy_o      = busy;

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         dp_valid   <= 1'b0;
         dp_write   <= 1'b0;
         dp_hi_zero <= 1'b0;
         dp_addr    <= 8'h00;
      end else if (hreadyout_o) begin
         dp_valid   <= accept;
         dp_write   <= hwrite_i;
         dp_hi_zero <= (haddr_i[31:8] == 24'h0);
         dp_addr    <= haddr_i[7:0];
      end
   end

   // ======================================================
   // operand addressing
   wire        use_index = ext_en & ~dec.bank_sel
                           & (dec.operand_byte <= sba_pkg::INDEX_LIMIT);
   wire [5:0]  acc_bank  = (dec.operand_byte <= sba_pkg::INDEX_LIMIT)
                           ? sba_pkg::LOW_BANK : sba_pkg::SFR_BANK;
   wire [13:0] op_addr   =
      dec.bank_sel ? {bank_select_register, dec.operand_byte} :
      use_index    ? index_base + {6'h00, dec.operand_byte} :
                     {acc_bank, dec.operand_byte};
   // storage only holds the low address bits: higher addresses alias
   wire [IDXW-1:0] op_idx = op_addr[IDXW-1:0];

   // ======================================================
   // arithmetic
   wire        is_reg   = (dec.op == sba_pkg::OP_SUB_REG);
   wire [7:0]  minuend  = is_reg ? acc : dec.operand_byte;
   wire [7:0]  subtrah  = is_reg ? opnd : acc;
   wire        borrow   = is_reg & ~flags.c;

   sba_sub_alu u_alu (
      .minuend_i    (minuend),
      .subtrahend_i (subtrah),
      .borrow_i     (borrow),
      .result_o     (alu_res),
      .flags_o      (alu_flags)
   );

   wire q4_reg  = (state == sba_pkg::ST_Q4) & is_reg;
   wire q4_live = (state == sba_pkg::ST_Q4) & (dec.op != sba_pkg::OP_NONE);
   wire acc_wr  = q4_live & ~(is_reg & dec.to_reg);
   wire ram_wr  = q4_reg & dec.to_reg;

   // ======================================================
   // quarter-phase sequencer
   wire sba_pkg::sba_instr_s dec_now = decode(instr);
   always_comb begin
      case (state)
         sba_pkg::ST_IDLE: next_state = start ? sba_pkg::ST_Q1
                                              : sba_pkg::ST_IDLE;
         sba_pkg::ST_Q1:   next_state = sba_pkg::ST_Q2;
         sba_pkg::ST_Q2:   next_state = sba_pkg::ST_Q3;
         sba_pkg::ST_Q3:   next_state = sba_pkg::ST_Q4;
         sba_pkg::ST_Q4:   next_state = sba_pkg::ST_IDLE;
         default:          next_state = sba_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         state     <= sba_pkg::ST_IDLE;
         dec       <= '0;
         opnd      <= 8'h00;
         res       <= 8'h00;
         res_flags <= sba_pkg::FLAGS_RST;
         last_addr <= 14'h0000;
         illegal   <= 1'b0;
      end else begin
         state <= next_state;
         if (start) begin
            illegal <= 1'b0;
         end
         if (state == sba_pkg::ST_Q1) begin
            dec     <= dec_now;
            illegal <= (dec_now.op == sba_pkg::OP_NONE);
         end
         if (state == sba_pkg::ST_Q2 && is_reg) begin
            opnd      <= ram[op_idx];
            last_addr <= op_addr;
         end
         if (state == sba_pkg::ST_Q3) begin
            res       <= alu_res;
            res_flags <= alu_flags;
         end
      end
   end

   // ======================================================
   // architectural registers
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         acc                  <= sba_pkg::ACC_RST;
         flags                <= sba_pkg::FLAGS_RST;
         instr                <= sba_pkg::INSTR_RST;
         bank_select_register <= sba_pkg::BANK_SEL_RST;
         index_base           <= sba_pkg::INDEX_BASE_RST;
         ext_en               <= 1'b0;
      end else begin
         if (acc_wr) begin
            acc <= res;
         end else if (bus_wr && hit_acc) begin
            acc <= hwdata_i[7:0];
         end
         if (q4_live) begin
            flags <= res_flags;
         end else if (bus_wr && hit_stat) begin
            flags <= hwdata_i[4:0];
         end
         if (bus_wr && hit_instr) begin
            instr <= hwdata_i[15:0];
         end
         if (bus_wr && hit_bank) begin
            bank_select_register <= hwdata_i[5:0];
         end
         if (bus_wr && hit_base) begin
            index_base <= hwdata_i[13:0];
         end
         if (bus_wr && hit_ctrl) begin
            ext_en <= hwdata_i[sba_pkg::CTRL_EXT_BIT];
         end
      end
   end

   // bus and core never write storage together: the bus stalls while busy
   for (genvar i = 0; i < DEPTH; i++) begin : g_ram
      always_ff @(posedge clk_i or posedge reset_i) begin
         if (reset_i) begin
            ram[i] <= 8'h00;
         end else if (ram_wr && op_idx == IDXW'(i)) begin
            ram[i] <= res;
         end else if (bus_wr && hit_ram
                      && ram_word[IDXW-1:0] == IDXW'(i)) begin
            ram[i] <= hwdata_i[7:0];
         end
      end
   end

   // ======================================================
   // assertions
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   wire [7:0] exp_reg = acc - opnd - {7'h00, ~flags.c};
   wire       in_q3   = (state == sba_pkg::ST_Q3);

   property p_reg_math;
      in_q3 && is_reg |-> alu_res == exp_reg;
   endproperty
   a_reg_math: assert property (p_reg_math)
      else $error("register subtract result wrong");

   property p_to_acc;
      q4_reg && !dec.to_reg |=> acc == $past(res) && $stable(opnd);
   endproperty
   a_to_acc: assert property (p_to_acc)
      else $error("accumulator not written");

   property p_to_reg;
      q4_reg && dec.to_reg |=> ram[$past(op_idx)] == $past(res)
                               && $stable(acc);
   endproperty
   a_to_reg: assert property (p_to_reg)
      else $error("register target not written");

   property p_bank;
      (state == sba_pkg::ST_Q2) && is_reg && dec.bank_sel
         |-> op_addr == {bank_select_register, dec.operand_byte};
   endproperty
   a_bank: assert property (p_bank)
      else $error("bank select address wrong");

   property p_index;
      (state == sba_pkg::ST_Q2) && is_reg && !dec.bank_sel && ext_en
         && dec.operand_byte <= sba_pkg::INDEX_LIMIT
         |-> op_addr == index_base + {6'h00, dec.operand_byte};
   endproperty
   a_index: assert property (p_index)
      else $error("indexed offset address wrong");

   sequence s_quarters;
      state == sba_pkg::ST_Q2 ##1 state == sba_pkg::ST_Q3
         ##1 state == sba_pkg::ST_Q4 ##1 state == sba_pkg::ST_IDLE;
   endsequence
   property p_quarters;
      state == sba_pkg::ST_Q1 |=> s_quarters;
   endproperty
   a_quarters: assert property (p_quarters)
      else $error("quarter phases out of order");

   property p_lit_math;
      (state == sba_pkg::ST_Q4) && dec.op == sba_pkg::OP_SUB_LIT
         |=> acc == $past(dec.operand_byte) - $past(acc);
   endproperty
   a_lit_math: assert property (p_lit_math)
      else $error("literal subtract result wrong");

   property p_lit_one_cycle;
      start && dec_now.op == sba_pkg::OP_SUB_LIT
         |=> ##3 q4_live ##1 !busy;
   endproperty
   a_lit_one_cycle: assert property (p_lit_one_cycle)
      else $error("literal subtract not done in four phases");

   property p_flags;
      q4_live |=> flags.z == ($past(res) == 8'h00)
                  && flags.n == $past(res[7])
                  && (!$past(dec.op == sba_pkg::OP_SUB_LIT)
                      || flags.c == ($past(dec.operand_byte)
                                     >= $past(acc)));
   endproperty
   a_flags: assert property (p_flags)
      else $error("status flags wrong");

   property p_dc_ov;
      in_q3 && dec.op == sba_pkg::OP_SUB_LIT
         |=> res_flags.dc == ($past(dec.operand_byte[3:0])
                              >= $past(acc[3:0]))
             && res_flags.ov == ($past(dec.operand_byte[7] ^ acc[7])
                                 && (res[7] != $past(dec.operand_byte[7])));
   endproperty
   a_dc_ov: assert property (p_dc_ov)
      else $error("digit carry or signed wrap wrong");

   c_reg_to_acc: cover property (q4_reg && !dec.to_reg);
   c_reg_to_ram: cover property (q4_reg && dec.to_reg && use_index);
   c_lit: cover property (q4_live && dec.op == sba_pkg::OP_SUB_LIT);
   c_stall: cover property (dp_valid && busy ##1 dp_valid && busy);

endmodule : sba_core

// *** dv/sba_ahb_master.sv ***
module sba_ahb_master (
   // clock
   input  wire logic        clk_i,
   // bus request
   output logic             hsel_o,
   output logic      [31:0] haddr_o,
   output logic      [1:0]  htrans_o,
   output logic             hwrite_o,
   output logic      [2:0]  hsize_o,
   output logic      [31:0] hwdata_o,
   // bus answer
   input  wire logic        hready_i,
   input  wire logic [31:0] hrdata_i
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      hsel_o   = 1'b0;
      haddr_o  = 32'h0000_0000;
      htrans_o = 2'h0;
      hwrite_o = 1'b0;
      hsize_o  = 3'h2;
      hwdata_o = 32'h0000_0000;
   end

   // ======================================================
   // single word transfer; waits only on hready
   task automatic xfer(input logic wr, input logic [31:0] addr,
                       input logic [31:0] wdata,
                       output logic [31:0] rdata);
      @(posedge clk_i);
      hsel_o   <= 1'b1;
      haddr_o  <= addr;
      htrans_o <= 2'h2;
      hwrite_o <= wr;
      @(posedge clk_i);
      while (hready_i !== 1'b1) @(posedge clk_i);
      hsel_o   <= 1'b0;
      htrans_o <= 2'h0;
      if (wr) hwdata_o <= wdata;
      @(posedge clk_i);
      while (hready_i !== 1'b1) @(posedge clk_i);
      rdata = hrdata_i;
      // released lines must not keep showing the last value
      hwdata_o <= ~hwdata_o;
      haddr_o  <= ~addr;
   endtask : xfer

endmodule : sba_ahb_master

// *** dv/sba_tb_top.sv ***
module sba_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int DEPTH = 32;

   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        hsel, hwrite, hready, hresp, busy;
   logic [31:0] haddr, hwdata, hrdata, rdv;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   int          err_count = 0;
   int          n_compared = 0;

   always #12.5ns clk = ~clk;

   sba_core #(.DEPTH(DEPTH)) DUT (
      .clk_i(clk), .reset_i(reset), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
      .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready),
      .hresp_o(hresp), .hrdata_o(hrdata), .busy_o(busy));

   sba_ahb_master u_mst (
      .clk_i(clk), .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans),
      .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata),
      .hready_i(hready), .hrdata_i(hrdata));

   // ======================================================
   // access and compare tasks
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] x;
      u_mst.xfer(1'b1, a, d, x);
   endtask : wr

   task automatic rd(input logic [31:0] a, output logic [31:0] d);
      u_mst.xfer(1'b0, a, 32'h0000_0000, d);
   endtask : rd

   task automatic check_word(input logic [31:0] got,
                             input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check_word

   task automatic check_count(input int got, input int exp,
                              input string what);
      n_compared++;
      if (got != exp) begin
         err_count++;
         $display("ERROR %0t: %s got %0d exp %0d", $time, what, got, exp);
      end
   endtask : check_count

   task automatic finish_test();
      $display("comparisons %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : finish_test

   // expected {n, ov, z, dc, c, result}
   function automatic logic [12:0] ref_sub(input logic [7:0] a,
                                           input logic [7:0] b,
                                           input logic bin);
      logic [8:0] full;
      logic [4:0] nib;
      full = {1'b0, a} - {1'b0, b} - {8'h00, bin};
      nib = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bin};
      return {full[7], (a[7] != b[7]) && (full[7] != a[7]),
              full[7:0] == 8'h00, ~nib[4], ~full[8], full[7:0]};
   endfunction : ref_sub

   // start an instruction; optionally count the busy cycles
   task automatic go(input logic [15:0] ins, input logic ext,
                     input logic cnt);
      int nb;
      nb = 0;
      wr(sba_pkg::INSTR_OFS, {16'h0000, ins});
      wr(sba_pkg::CTRL_OFS, {30'h0, ext, 1'b1});
      if (cnt) begin
         repeat (6) begin
            @(posedge clk);
            nb += int'(busy === 1'b1);
         end
         check_count(nb, 4, "busy cycles");
      end
   endtask : go

   // ======================================================
   // test tables
   logic [7:0]  r_acc [6] = '{8'h02, 8'h05, 8'h02, 8'h80, 8'h10, 8'h05};
   logic [7:0]  r_opd [6] = '{8'h03, 8'h02, 8'h01, 8'h01, 8'h01, 8'h02};
   logic [5:0]  r_c = 6'b011011;
   logic [5:0]  r_d = 6'b010101;
   logic [7:0]  l_k   [4] = '{8'h02, 8'h02, 8'h02, 8'h7F};
   logic [7:0]  l_acc [4] = '{8'h01, 8'h02, 8'h03, 8'hFF};
   logic [7:0]  a_f   [5] = '{8'h23, 8'h80, 8'h23, 8'h5F, 8'h60};
   logic [13:0] a_exp [5] = '{14'h0523, 14'h3F80, 14'h0123, 14'h015F,
                              14'h3F60};
   logic [4:0]  a_a = 5'b00001;
   logic [4:0]  a_x = 5'b11100;
   logic [12:0] e;

   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      $display("ERROR %0t: watchdog expired", $time);
      finish_test();
   end

   initial begin
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      // ======================================================
      // reset values and unmapped access
      rd(sba_pkg::ACC_OFS, rdv);
      check_word(rdv, 32'h0000_0000, "acc after reset");
      wr(32'h0000_0100, 32'hFFFF_FFFF);
      rd(32'h0000_0100, rdv);
      check_word(rdv, 32'h0000_0000, "unmapped read");
      check_word({31'h0, hresp}, 32'h0000_0000, "response");
      $display("test reset done");
      // ======================================================
      // register subtract with borrow; operand f=23h is ram byte 3
      for (int i = 0; i < 6; i++) begin
         e = ref_sub(r_acc[i], r_opd[i], ~r_c[i]);
         wr(sba_pkg::ACC_OFS, {24'h0, r_acc[i]});
         wr(sba_pkg::STATUS_OFS, {31'h0, r_c[i]});
         wr(32'h0000_008C, {24'h0, r_opd[i]});
         go({sba_pkg::SUB_REG_PREFIX, r_d[i], 1'b0, 8'h23}, 1'b0, 1'b1);
         rd(sba_pkg::ACC_OFS, rdv);
         check_word(rdv, {24'h0, r_d[i] ? r_acc[i] : e[7:0]}, "acc");
         rd(32'h0000_008C, rdv);
         check_word(rdv, {24'h0, r_d[i] ? e[7:0] : r_opd[i]}, "reg");
         rd(sba_pkg::STATUS_OFS, rdv);
         check_word(rdv, {27'h0, e[12:8]}, "reg flags");
      end
      $display("test register subtract done");
      // ======================================================
      // literal subtract; the first case reads while busy
      for (int i = 0; i < 4; i++) begin
         e = ref_sub(l_k[i], l_acc[i], 1'b0);
         wr(sba_pkg::ACC_OFS, {24'h0, l_acc[i]});
         go({sba_pkg::SUB_LIT_PREFIX, l_k[i]}, 1'b0, i != 0);
         rd(sba_pkg::ACC_OFS, rdv);
         check_word(rdv, {24'h0, e[7:0]}, "literal acc");
         rd(sba_pkg::STATUS_OFS, rdv);
         check_word(rdv, {27'h0, e[12:8]}, "literal flags");
      end
      $display("test literal subtract done");
      // ======================================================
      // operand addressing modes
      wr(sba_pkg::BANK_SEL_OFS, 32'h0000_0005);
      wr(sba_pkg::INDEX_BASE_OFS, 32'h0000_0100);
      for (int i = 0; i < 5; i++) begin
         go({sba_pkg::SUB_REG_PREFIX, a_x[i], a_a[i], a_f[i]}, a_x[i], 1'b0);
         rd(sba_pkg::LAST_ADDR_OFS, rdv);
         check_word(rdv, {18'h0, a_exp[i]}, "operand address");
      end
      $display("test addressing done");
      // ======================================================
      // undecoded opcode: phases run, nothing written, flag set
      wr(sba_pkg::ACC_OFS, 32'h0000_005A);
      go(16'h0000, 1'b1, 1'b1);
      rd(sba_pkg::CTRL_OFS, rdv);
      check_word(rdv, (32'h1 << sba_pkg::CTRL_ILLEGAL_BIT)
                 | (32'h1 << sba_pkg::CTRL_EXT_BIT), "illegal flag");
      rd(sba_pkg::ACC_OFS, rdv);
      check_word(rdv, 32'h0000_005A, "acc kept");
      go({sba_pkg::SUB_LIT_PREFIX, 8'h5A}, 1'b0, 1'b0);
      rd(sba_pkg::CTRL_OFS, rdv);
      check_word(rdv, 32'h0000_0000, "illegal cleared");
      rd(sba_pkg::ACC_OFS, rdv);
      check_word(rdv, 32'h0000_0000, "literal self");
      $display("test undecoded opcode done");
      finish_test();
   end

endmodule : sba_tb_top
